// File: rtl/tes_regs.svh
// Purpose: constants for the two-wire serial memory target
// Assumes: 100 MHz system clock
// Notes:   timing counts are whole system-clock cycles
`ifndef TES_REGS_SVH
`define TES_REGS_SVH

// device-type pattern in the top nibble of the device address word
`define TES_DEV_TYPE      4'hA
// word address width and page offset width
`define TES_ADDR_BITS     14
`define TES_PAGE_BITS     6
// byte-transfer bit counts
`define TES_BYTE_BITS     4'h8
`define TES_LAST_TX_BIT   4'h7
// program cycle time in ms and the clock rate in MHz
`define TES_PROG_TIME_MS  5
`define TES_CLK_MHZ       100
// longest time rounds down: whole cycles of the system clock
`define TES_PROG_CYCLES   (`TES_PROG_TIME_MS * 1000 * `TES_CLK_MHZ)

`endif

// File: rtl/tes_pkg.sv
// Purpose: shared types of the two-wire serial memory target
// Assumes: nothing
// Notes:   constants live in tes_regs.svh
package tes_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_RACK,
		ST_PROG
	} tes_state_t;

	typedef enum logic [1:0] {
		KIND_DEV,
		KIND_AHI,
		KIND_ALO,
		KIND_DATA
	} tes_kind_t;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       wp;
		logic [2:0] strap;
	} tes_pins_t;

endpackage

// File: rtl/tes_pin_sync.sv
// Purpose: two-flop synchroniser for every pin of the target
// Assumes: pins are asynchronous to clk_sys
// Notes:   idle value is all ones so that release makes no start
`timescale 1ns/100ps
`default_nettype none

module tes_pin_sync (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// pins
	input  wire tes_pkg::tes_pins_t pinsRaw,
	output tes_pkg::tes_pins_t      pinsSync
);
	import tes_pkg::*;

	tes_pins_t meta_q;
	tes_pins_t sync_q;

	// first flop is read only by the second
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= pinsRaw;
			sync_q <= meta_q;
		end
	end

	assign pinsSync = sync_q;

endmodule // tes_pin_sync

`default_nettype wire

// File: rtl/tes_eeprom_slave.sv
// Purpose: two-wire target of a 16384 x 8 nonvolatile memory
// Assumes: bus clock far slower than clk_sys; sda released by others
// Notes:   array has no reset, so its contents persist; rst_n clears the counter
`timescale 1ns/100ps
`default_nettype none
`include "tes_regs.svh"

// Function
// - sda changing while scl high is start or stop, never data
// - start is sda falling with scl high; every command opens with it
// - stop is sda rising with scl high; after a read, enter standby
// - words are eight bits; device pulls sda low on the ninth clock
// - standby after power-up, and after stop once programming ends
// - start, nine clocks, start, stop leaves the device ready
// - each command begins with an eight-bit device address word
// - next three address bits must match the three strap pins
// - last address bit one means read, zero means write
// - match is acknowledged; mismatch returns to standby and ignores
// - write-protect pin high blocks writes to the whole array
// - byte write: two address bytes, one data byte, each acked, stop
// - stop after write starts self-timed program cycle, deaf meanwhile
// - program time counts from the stop to the cycle end
// - page write takes up to 64 bytes, each acked, ended by stop
// - write increments only low six bits, wrapping inside the page
// - polls during programming get no ack until the cycle ends
// - address counter holds last address plus one, persists
// - read counter wraps from last byte to first byte of array
// - current read outputs byte at counter; no ack then stop
// - each controller ack increments address and sends next byte
// - sample on rising scl, change output on falling scl
// - 14-bit word address, 256 pages of 64; upper bits ignored
module tes_eeprom_slave #(
	parameter int ADDR_BITS   = `TES_ADDR_BITS,
	parameter int PAGE_BITS   = `TES_PAGE_BITS,
	parameter int PROG_CYCLES = `TES_PROG_CYCLES
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// serial bus
	input  wire logic scl,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	// straps and protection
	input  wire logic chipSelectStrap2,
	input  wire logic chipSelectStrap1,
	input  wire logic chipSelectStrap0,
	input  wire logic writeProtect,
	// status
	output logic      standby,
	output logic      programBusy
);
	import tes_pkg::*;

	localparam int DEPTH  = 1 << ADDR_BITS;
	localparam int PAGE   = 1 << PAGE_BITS;
	localparam int PROG_W = $clog2(PROG_CYCLES + 1);
	localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(PROG_CYCLES - 1);
	localparam logic [PAGE_BITS:0] PAGE_END = (PAGE_BITS + 1)'(PAGE);

	////////////////////////////////////////////////////////////////////
	// pin sampling and bus conditions

	tes_pins_t pinsRaw;
	tes_pins_t pinsSync;
	logic      sclPrev_q;
	logic      sdaPrev_q;
	logic      sclRise;
	logic      sclFall;
	logic      startDet;
	logic      stopDet;

	assign pinsRaw = '{scl:   scl,
	                   sda:   sdaIn,
	                   wp:    writeProtect,
	                   strap: {chipSelectStrap2, chipSelectStrap1,
	                           chipSelectStrap0}};

	tes_pin_sync u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.pinsRaw  (pinsRaw),
		.pinsSync (pinsSync)
	);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= pinsSync.scl;
			sdaPrev_q <= pinsSync.sda;
		end
	end

	assign sclRise = pinsSync.scl & ~sclPrev_q;
	assign sclFall = ~pinsSync.scl & sclPrev_q;
	// sda moving while scl stays high is never data
	assign startDet = pinsSync.scl & sclPrev_q & sdaPrev_q
	                & ~pinsSync.sda;
	assign stopDet  = pinsSync.scl & sclPrev_q & ~sdaPrev_q
	                & pinsSync.sda;

	////////////////////////////////////////////////////////////////////
	// helpers

	function automatic tes_kind_t nextKind(input tes_kind_t k);
		unique case (k)
			KIND_DEV: nextKind = KIND_AHI;
			KIND_AHI: nextKind = KIND_ALO;
			default:  nextKind = KIND_DATA;
		endcase
	endfunction

	// write addressing stays inside the page
	function automatic logic [ADDR_BITS-1:0] pageNext(
		input logic [ADDR_BITS-1:0] a);
		pageNext = {a[ADDR_BITS-1:PAGE_BITS],
		            a[PAGE_BITS-1:0] + 1'b1};
	endfunction

	////////////////////////////////////////////////////////////////////
	// storage

	logic [7:0]           memArray [DEPTH];
	logic [7:0]           pageBuf  [PAGE];
	logic [PAGE-1:0]      mask_q;
	logic [ADDR_BITS-1:0] addr_q;
	logic [7:0]           addrHi_q;
	logic [7:0]           memRd;

	assign memRd = memArray[addr_q];

	////////////////////////////////////////////////////////////////////
	// byte engine

	tes_state_t        state_q;
	tes_kind_t         kind_q;
	logic [3:0]        bitCnt_q;
	logic [7:0]        shift_q;
	logic              rw_q;
	logic              sdaOe_q;
	logic              masterAck_q;
	logic [PROG_W-1:0] progCnt_q;
	logic [PAGE_BITS:0] progIdx_q;
	logic [ADDR_BITS-PAGE_BITS-1:0] progPage_q;
	logic              byteDone;
	logic              devMatch;
	logic              readLoad;
	logic              dataStore;
	logic              progStart;
	logic              progDone;

	assign byteDone  = state_q == ST_RX && sclFall
	                 && bitCnt_q == `TES_BYTE_BITS;
	assign devMatch  = shift_q[7:4] == `TES_DEV_TYPE
	                 && shift_q[3:1] == pinsSync.strap;
	assign readLoad  = sclFall && ((state_q == ST_ACK && kind_q == KIND_DEV
	                 && rw_q) || (state_q == ST_RACK && masterAck_q));
	assign dataStore = byteDone && kind_q == KIND_DATA;
	// a protected write is acknowledged but never programmed
	assign progStart = stopDet && state_q != ST_PROG && |mask_q
	                 && !pinsSync.wp;
	assign progDone  = state_q == ST_PROG && progCnt_q == PROG_LAST;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q     <= ST_IDLE;
			kind_q      <= KIND_DEV;
			bitCnt_q    <= 4'h0;
			shift_q     <= 8'h00;
			rw_q        <= 1'b0;
			sdaOe_q     <= 1'b0;
			masterAck_q <= 1'b0;
		end else if (state_q == ST_PROG) begin
			// inputs ignored until the cycle ends
			if (progDone) begin
				state_q <= ST_IDLE;
			end
		end else if (startDet) begin
			state_q  <= ST_RX;
			kind_q   <= KIND_DEV;
			bitCnt_q <= 4'h0;
			sdaOe_q  <= 1'b0;
		end else if (stopDet) begin
			sdaOe_q <= 1'b0;
			state_q <= progStart ? ST_PROG : ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
				end
				ST_RX: begin
					if (sclRise && bitCnt_q != `TES_BYTE_BITS) begin
						shift_q  <= {shift_q[6:0], pinsSync.sda};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (byteDone) begin
						if (kind_q != KIND_DEV || devMatch) begin
							sdaOe_q <= 1'b1;
							state_q <= ST_ACK;
						end else begin
							state_q <= ST_IDLE;
						end
						if (kind_q == KIND_DEV) begin
							rw_q <= shift_q[0];
						end
					end
				end
				ST_ACK: begin
					if (sclFall) begin
						bitCnt_q <= 4'h0;
						if (readLoad) begin
							state_q <= ST_TX;
							shift_q <= memRd;
							sdaOe_q <= ~memRd[7];
						end else begin
							state_q <= ST_RX;
							sdaOe_q <= 1'b0;
							kind_q  <= nextKind(kind_q);
						end
					end
				end
				ST_TX: begin
					if (sclFall) begin
						if (bitCnt_q != `TES_LAST_TX_BIT) begin
							shift_q  <= {shift_q[6:0], 1'b0};
							sdaOe_q  <= ~shift_q[6];
							bitCnt_q <= bitCnt_q + 4'h1;
						end else begin
							sdaOe_q <= 1'b0;
							state_q <= ST_RACK;
						end
					end
				end
				ST_RACK: begin
					if (sclRise) begin
						masterAck_q <= ~pinsSync.sda;
					end else if (sclFall) begin
						bitCnt_q <= 4'h0;
						if (readLoad) begin
							state_q <= ST_TX;
							shift_q <= memRd;
							sdaOe_q <= ~memRd[7];
						end else begin
							// no ack: wait quietly for the stop
							state_q <= ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// address counter

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_q   <= '0;
			addrHi_q <= 8'h00;
		end else if (byteDone && kind_q == KIND_AHI) begin
			addrHi_q <= shift_q;
		end else if (byteDone && kind_q == KIND_ALO) begin
			// unused high bits of the first address byte drop out
			addr_q <= {addrHi_q[ADDR_BITS-9:0], shift_q};
		end else if (dataStore) begin
			addr_q <= pageNext(addr_q);
		end else if (readLoad) begin
			addr_q <= addr_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// page buffer and programming

	// a repeated start abandons any unfinished write
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (progDone) begin
			mask_q <= '0;
		end else if (state_q != ST_PROG && startDet) begin
			mask_q <= '0;
		end else if (dataStore) begin
			mask_q[addr_q[PAGE_BITS-1:0]] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dataStore) begin
			pageBuf[addr_q[PAGE_BITS-1:0]] <= shift_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			progCnt_q  <= '0;
			progIdx_q  <= '0;
			progPage_q <= '0;
		end else if (progStart) begin
			progCnt_q  <= '0;
			progIdx_q  <= '0;
			progPage_q <= addr_q[ADDR_BITS-1:PAGE_BITS];
		end else if (state_q == ST_PROG) begin
			progCnt_q <= progCnt_q + 1'b1;
			if (progIdx_q != PAGE_END) begin
				progIdx_q <= progIdx_q + 1'b1;
			end
		end
	end

	// only bytes received in this write touch the array
	always_ff @(posedge clk_sys) begin
		if (state_q == ST_PROG && progIdx_q != PAGE_END
		    && mask_q[progIdx_q[PAGE_BITS-1:0]]) begin
			memArray[{progPage_q, progIdx_q[PAGE_BITS-1:0]}] <=
				pageBuf[progIdx_q[PAGE_BITS-1:0]];
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign sdaOut      = 1'b0;
	assign sdaOe       = sdaOe_q;
	assign standby     = state_q == ST_IDLE;
	assign programBusy = state_q == ST_PROG;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence byteEndSeq;
		state_q == ST_RX && sclFall && bitCnt_q == `TES_BYTE_BITS;
	endsequence

	sequence stopSeenSeq;
		stopDet && state_q != ST_PROG;
	endsequence

	start_resync_a: assert property (
		startDet && state_q != ST_PROG |=> state_q == ST_RX
		&& kind_q == KIND_DEV && bitCnt_q == 4'h0 && !sdaOe_q)
		else $error("start did not restart the address word");

	read_stop_a: assert property (
		stopSeenSeq ##0 (state_q inside {ST_TX, ST_RACK})
		|=> state_q == ST_IDLE && !sdaOe_q)
		else $error("stop after read did not reach standby");

	ack_hold_a: assert property (
		byteEndSeq ##0 (kind_q != KIND_DEV)
		|=> (sdaOe_q && state_q == ST_ACK) [*2])
		else $error("received word not acknowledged");

	nomatch_a: assert property (
		byteEndSeq ##0 (kind_q == KIND_DEV && !devMatch)
		|=> state_q == ST_IDLE && !sdaOe_q)
		else $error("foreign address was answered");

	wp_block_a: assert property (
		stopSeenSeq ##0 pinsSync.wp |=> state_q != ST_PROG)
		else $error("write started while protected");

	prog_enter_a: assert property (
		stopSeenSeq ##0 (|mask_q && !pinsSync.wp)
		|=> state_q == ST_PROG && progCnt_q == '0)
		else $error("stop after write did not start programming");

	prog_deaf_a: assert property (
		state_q == ST_PROG && !progDone
		|=> state_q == ST_PROG && !sdaOe_q)
		else $error("device answered during programming");

	page_wrap_a: assert property (
		dataStore |=> addr_q[ADDR_BITS-1:PAGE_BITS]
		== $past(addr_q[ADDR_BITS-1:PAGE_BITS])
		&& addr_q[PAGE_BITS-1:0] == $past(addr_q[PAGE_BITS-1:0]) + 1'b1)
		else $error("write address left its page");

	read_incr_a: assert property (
		readLoad |=> addr_q == $past(addr_q) + 1'b1 && state_q == ST_TX)
		else $error("read counter did not advance");

	oe_on_fall_a: assert property (
		$changed(sdaOe_q) |-> $past(sclFall || startDet || stopDet))
		else $error("sda drive changed outside a falling scl");

endmodule // tes_eeprom_slave

`default_nettype wire

// File: bench/tes_host.sv
// Purpose: behavioural two-wire bus controller facing the memory target
// Assumes: sda is open drain with a pull-up; each bus phase >= 4 clk_sys
// Notes:   scl stands high between frames, as a real controller leaves it
`timescale 1ns/100ps
`default_nettype none

module tes_host (
	// clock
	input  wire logic clk_sys,
	// bus
	input  wire logic sdaBus,
	output logic      scl,
	output logic      sdaDrv
);
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// works from idle or from scl low, so it doubles as repeated start
	task automatic start();
		sdaDrv <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sdaDrv <= 1'b0;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic stop();
		sdaDrv <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sdaDrv <= 1'b1;
		tick(8);
	endtask
	// sda moves two edges after scl falls, never with it
	task automatic bitIo(input logic b, output logic s);
		sdaDrv <= b;
		tick(4);
		scl <= 1'b1;
		tick(2);
		@(negedge clk_sys);
		s = sdaBus;
		tick(2);
		scl <= 1'b0;
		tick(2);
	endtask
	task automatic xfer(input logic [7:0] w, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(w[i], s);
		end
		bitIo(1'b1, s);
		ack = ~s;
	endtask
	// ack asks for the next byte; the last one gets none
	task automatic rd(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(1'b1, d[i]);
		end
		bitIo(~more, s);
	endtask
	task automatic recover();
		logic s;
		start();
		repeat (9) bitIo(1'b1, s);
		start();
		stop();
	endtask
endmodule // tes_host
`default_nettype wire

// File: bench/tb_two_wire_eeprom_slave.sv
// Purpose: self-checking bench of the two-wire memory target
// Assumes: program cycle shortened to PROG clocks
// Notes:   array starts unknown, so every read follows a write
`timescale 1ns/100ps
`default_nettype none

module tb_two_wire_eeprom_slave;
	localparam int PROG = 200;
	logic       clk_sys;
	logic       rst_n;
	logic       writeProtect;
	logic [2:0] strapSet;
	logic       sdaOut;
	logic       sdaOe;
	logic       standby;
	logic       programBusy;
	logic       scl;
	logic       sdaDrv;
	logic       ack;
	wire logic  sdaBus;
	int         bad_count = 0;
	int         checks = 0;
	int         cycles = 0;

	// open-drain wire with pull-up
	assign sdaBus = sdaDrv & ~(sdaOe & ~sdaOut);

	tes_eeprom_slave #(.PROG_CYCLES(PROG)) u_dut (
		.clk_sys         (clk_sys),
		.rst_n           (rst_n),
		.scl             (scl),
		.sdaIn           (sdaBus),
		.sdaOut          (sdaOut),
		.sdaOe           (sdaOe),
		.chipSelectStrap2(strapSet[2]),
		.chipSelectStrap1(strapSet[1]),
		.chipSelectStrap0(strapSet[0]),
		.writeProtect    (writeProtect),
		.standby         (standby),
		.programBusy     (programBusy)
	);
	tes_host u_host (
		.clk_sys(clk_sys),
		.sdaBus (sdaBus),
		.scl    (scl),
		.sdaDrv (sdaDrv)
	);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] s, e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s exp %h seen %h", what, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// look between edges so flag updates have landed
	task automatic flags(input logic busy, input logic sb);
		@(negedge clk_sys);
		check("programBusy", programBusy, busy);
		check("standby", standby, sb);
		@(posedge clk_sys);
	endtask
	task automatic idleWait();
		int n;
		n = 0;
		while (standby !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		check("standbyEnd", standby, 1'b1);
		@(posedge clk_sys);
	endtask
	// top two bits of the high byte are set: they must be ignored
	task automatic addrPhase(input logic [13:0] a);
		u_host.start();
		u_host.xfer({4'hA, strapSet, 1'b0}, ack);
		check("ackDev", ack, 1'b1);
		u_host.xfer({2'b11, a[13:8]}, ack);
		check("ackHi", ack, 1'b1);
		u_host.xfer(a[7:0], ack);
		check("ackLo", ack, 1'b1);
	endtask
	task automatic writeBytes(input logic [13:0] a, input logic [7:0] d[$]);
		addrPhase(a);
		foreach (d[i]) begin
			u_host.xfer(d[i], ack);
			check("ackData", ack, 1'b1);
		end
		u_host.stop();
	endtask
	task automatic readBytes(input logic [13:0] a, input logic rnd,
		input logic [7:0] e[$]);
		logic [7:0] d;
		if (rnd) begin
			addrPhase(a);
		end
		u_host.start();
		u_host.xfer({4'hA, strapSet, 1'b1}, ack);
		check("ackRead", ack, 1'b1);
		foreach (e[i]) begin
			u_host.rd(i < e.size() - 1, d);
			check("readData", d, e[i]);
		end
		u_host.stop();
		flags(1'b0, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic tReject();
		logic [7:0] bad[2];
		bad = '{{4'hA, ~strapSet, 1'b0}, {4'hB, strapSet, 1'b1}};
		foreach (bad[i]) begin
			u_host.start();
			u_host.xfer(bad[i], ack);
			check("ackBad", ack, 1'b0);
			u_host.stop();
			flags(1'b0, 1'b1);
		end
		$display("test reject done");
	endtask
	task automatic tByte();
		int n;
		n = 0;
		writeBytes(14'h1234, '{8'h5A});
		while (programBusy === 1'b1 && n < 1000) begin
			@(negedge clk_sys);
			n++;
		end
		check("progLen", n > PROG - 12 && n <= PROG, 1'b1);
		@(posedge clk_sys);
		readBytes(14'h1234, 1'b1, '{8'h5A});
		$display("test byte write done");
	endtask
	// starts on the last byte of a page, so the rest wrap to its start
	task automatic tPage();
		writeBytes(14'h00BF, '{8'h11, 8'h22, 8'h33});
		u_host.start();
		u_host.xfer({4'hA, strapSet, 1'b0}, ack);
		check("ackPoll", ack, 1'b0);
		idleWait();
		readBytes(14'h0080, 1'b1, '{8'h22, 8'h33});
		readBytes(14'h00BF, 1'b1, '{8'h11});
		$display("test page write done");
	endtask
	task automatic tWrap();
		writeBytes(14'h3FFF, '{8'hC3});
		idleWait();
		writeBytes(14'h0000, '{8'h3C});
		idleWait();
		readBytes(14'h3FFF, 1'b1, '{8'hC3, 8'h3C});
		readBytes(14'h3FFF, 1'b1, '{8'hC3});
		readBytes(14'h0000, 1'b0, '{8'h3C});
		$display("test read wrap done");
	endtask
	task automatic tProtect();
		writeProtect <= 1'b1;
		writeBytes(14'h0000, '{8'h99});
		flags(1'b0, 1'b1);
		writeProtect <= 1'b0;
		readBytes(14'h0000, 1'b1, '{8'h3C});
		$display("test protect done");
	endtask
	// abandon a write after its device address, then recover the bus
	task automatic tRecover();
		u_host.start();
		u_host.xfer({4'hA, strapSet, 1'b0}, ack);
		u_host.recover();
		flags(1'b0, 1'b1);
		readBytes(14'h3FFF, 1'b1, '{8'hC3});
		// stop while the first read byte is still going out
		addrPhase(14'h3FFF);
		u_host.start();
		u_host.xfer({4'hA, strapSet, 1'b1}, ack);
		check("ackCut", ack, 1'b1);
		u_host.stop();
		flags(1'b0, 1'b1);
		$display("test recover done");
	endtask
	initial begin
		rst_n = 1'b0;
		writeProtect = 1'b0;
		strapSet = 3'b101;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		flags(1'b0, 1'b1);
		tReject();
		tByte();
		tPage();
		tWrap();
		tProtect();
		tRecover();
		results();
	end
endmodule // tb_two_wire_eeprom_slave
`default_nettype wire
